/* File: rtl/fsp_pkg.sv */
package fsp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int FLASH_AW = 15;
  localparam int REG_AW = 4;
  localparam int REG_DW = 8;
  localparam int ARM_CW = 3;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [REG_AW-1:0] CTRL_ADDR = 4'h0;
  localparam logic [REG_AW-1:0] STATUS_ADDR = 4'h1;
  localparam logic [REG_AW-1:0] LOCK_ADDR = 4'h2;

  // self_program_control_reg bit positions
  localparam int CTRL_SPM_EN = 0;
  localparam int CTRL_ERASE = 1;
  localparam int CTRL_WRITE = 2;
  localparam int CTRL_LOCK_SET = 3;
  localparam int CTRL_RWW_REEN = 4;
  localparam int CTRL_RWW_BUSY = 6;

  // status register bit positions
  localparam int STAT_RST_SEL = 3;
  localparam int STAT_SIZE_LO = 4;
  localparam int STAT_SIZE_HI = 5;
  localparam int STAT_OP_BUSY = 6;
  localparam int STAT_HALT = 7;

  // lock bit positions, both in the lock register and in the spm data byte
  localparam int LOCK_APP_LO = 1;
  localparam int LOCK_APP_HI = 2;
  localparam int LOCK_BOOT_LO = 3;
  localparam int LOCK_BOOT_HI = 4;

  // ----------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------
  // the spm instruction must follow the control write within this many cycles
  localparam logic [ARM_CW-1:0] SPM_ARM_CYC = 3'h4;
  localparam logic [ARM_CW-1:0] ARM_ONE = 3'h1;
  localparam logic [FLASH_AW-1:0] APP_RESET_ADDR = 15'h0000;
  localparam logic [REG_DW-1:0] RDATA_RST = 8'h00;

  // boot size fuse codes
  localparam logic [1:0] SIZE_CODE_11 = 2'h3;
  localparam logic [1:0] SIZE_CODE_10 = 2'h2;
  localparam logic [1:0] SIZE_CODE_01 = 2'h1;
  localparam logic [1:0] SIZE_CODE_00 = 2'h0;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FSP_IDLE = 3'b001,
    FSP_ARMED = 3'b010,
    FSP_BUSY = 3'b100
  } fsp_state_t;

endpackage

/* File: rtl/fsp_protect.sv */
// Behaviour
// - spm starts programming only when executed from the boot section.
// - spm from the boot section may target any page, boot pages included.
// - boot section boundary comes from boot size fuses only.
// - during an rww page operation the cpu runs and reads no_read_while_write_section code.
// - during an no_read_while_write_section page operation the cpu is halted throughout.
// - rww section is never read during programming until re-enabled; here a page buffer load spm also reopens it.
// - rww busy flag reads one from an rww page operation until re-enable; a no_read_while_write_section operation does not set it.
//   here a page buffer load spm clears the flag as well as re-enable does.
// - boot section always lies inside the no_read_while_write_section section.
// - boot lock bits only programmed by software; only chip erase clears.
// - general lock modes do not affect spm writes or lpm reads.
// - lock bits are inverted: one unprogrammed, zero programmed.
// - app lock 11 no restriction; 10 blocks spm writes to app section.
// - app lock 00 blocks writes, boot-side lpm reads, masks app interrupts.
// - app lock 01 allows writes, blocks boot-side lpm reads, masks interrupts.
// - boot lock 11 no restriction; 10 blocks spm writes to boot section.
// - boot lock 00 blocks writes, app-side lpm reads, masks boot interrupts.
// - boot lock 01 allows writes, blocks app-side lpm reads, masks interrupts.
// - programmed boot reset fuse starts execution at the boot section start.
// - the cpu has no path to modify any fuse.
// - unprogrammed boot reset fuse uses application reset vector zero.
// - rww busy is set when an rww page erase or write starts.
//
// Local design decisions: strobed register access and the register offsets.
module fsp_protect
  import fsp_pkg::*;
#(
  parameter logic [FLASH_AW-1:0] NO_READ_WHILE_WRITE_SECTION_START = 15'h4800,
  parameter logic [FLASH_AW-1:0] FLASH_WORDS = 15'h5000,
  parameter logic [FLASH_AW-1:0] BOOT_WORDS_11 = 15'h0100,
  parameter logic [FLASH_AW-1:0] BOOT_WORDS_10 = 15'h0200,
  parameter logic [FLASH_AW-1:0] BOOT_WORDS_01 = 15'h0400,
  parameter logic [FLASH_AW-1:0] BOOT_WORDS_00 = 15'h0800
)(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [fsp_pkg::REG_AW-1:0] reg_addr,
  input wire logic [fsp_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [fsp_pkg::REG_DW-1:0] reg_rdata,
  // cpu side
  input wire logic [fsp_pkg::FLASH_AW-1:0] cpu_pc,
  input wire logic cpu_vectors_in_boot,
  input wire logic spm_exec,
  input wire logic [fsp_pkg::FLASH_AW-1:0] spm_addr,
  input wire logic [fsp_pkg::REG_DW-1:0] spm_r0,
  input wire logic [fsp_pkg::FLASH_AW-1:0] fetch_addr,
  input wire logic lpm_req,
  input wire logic [fsp_pkg::FLASH_AW-1:0] lpm_addr,
  output logic cpu_halt,
  output logic fetch_blocked,
  output logic lpm_denied,
  output logic irq_masked,
  output logic [fsp_pkg::FLASH_AW-1:0] reset_vector,
  // fuse and lock storage
  input wire logic [1:0] boot_size_fuses,
  input wire logic boot_reset_select_fuse,
  input wire logic app_lock_bit_hi,
  input wire logic app_lock_bit_lo,
  input wire logic boot_lock_bit_hi,
  input wire logic boot_lock_bit_lo,
  output logic lock_wr,
  output logic [3:0] lock_wr_data,
  // flash array
  input wire logic flash_done,
  output logic flash_erase_start,
  output logic flash_write_start,
  output logic [fsp_pkg::FLASH_AW-1:0] flash_page_addr
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    fsp_state_t st;
    logic [ARM_CW-1:0] arm_cnt;
    logic cmd_erase;
    logic cmd_write;
    logic cmd_lock_set;
    logic cmd_rww_reen;
    logic rww_busy;
    logic halt;
    logic erase_pulse;
    logic write_pulse;
    logic lock_wr;
    logic [3:0] lock_val;
    logic [FLASH_AW-1:0] page;
    logic [REG_DW-1:0] rdata;
  } fsp_regs_t;

  localparam fsp_regs_t REGS_RST = '{
    st: FSP_IDLE,
    arm_cnt: '0,
    cmd_erase: 1'b0,
    cmd_write: 1'b0,
    cmd_lock_set: 1'b0,
    cmd_rww_reen: 1'b0,
    rww_busy: 1'b0,
    halt: 1'b0,
    erase_pulse: 1'b0,
    write_pulse: 1'b0,
    lock_wr: 1'b0,
    lock_val: '0,
    page: '0,
    rdata: RDATA_RST
  };

  fsp_regs_t s_reg;
  fsp_regs_t s_next;

  // ----------------------------------------------------------------
  // section decode
  // ----------------------------------------------------------------
  logic [FLASH_AW-1:0] boot_start;
  logic [FLASH_AW-1:0] boot_start_raw;

  // fuse inputs only; nothing in this block can write them
  always_comb
  begin
    unique case (boot_size_fuses)
      SIZE_CODE_11: boot_start_raw = FLASH_WORDS - BOOT_WORDS_11;
      SIZE_CODE_10: boot_start_raw = FLASH_WORDS - BOOT_WORDS_10;
      SIZE_CODE_01: boot_start_raw = FLASH_WORDS - BOOT_WORDS_01;
      SIZE_CODE_00: boot_start_raw = FLASH_WORDS - BOOT_WORDS_00;
    endcase
  end

  // a boot size larger than the no_read_while_write_section area is clipped to it
  assign boot_start = (boot_start_raw < NO_READ_WHILE_WRITE_SECTION_START) ? NO_READ_WHILE_WRITE_SECTION_START : boot_start_raw;

  function automatic logic in_boot(input logic [FLASH_AW-1:0] a,
                                   input logic [FLASH_AW-1:0] bs);
    in_boot = (a >= bs);
  endfunction

  function automatic logic in_rww(input logic [FLASH_AW-1:0] a);
    in_rww = (a < NO_READ_WHILE_WRITE_SECTION_START);
  endfunction

  // ----------------------------------------------------------------
  // lock decode (programmed means zero)
  // ----------------------------------------------------------------
  // only the two boot lock fields are consulted; the general lock modes
  // are not even routed here, so they cannot gate spm or lpm
  logic app_wr_block;
  logic app_rd_block;
  logic boot_wr_block;
  logic boot_rd_block;

  assign app_wr_block = ~app_lock_bit_lo;
  assign app_rd_block = ~app_lock_bit_hi;
  assign boot_wr_block = ~boot_lock_bit_lo;
  assign boot_rd_block = ~boot_lock_bit_hi;

  // ----------------------------------------------------------------
  // cpu facing decode
  // ----------------------------------------------------------------
  logic pc_boot;
  logic spm_tgt_boot;
  logic spm_tgt_rww;
  logic spm_wr_block;
  logic rww_blocked;

  assign pc_boot = in_boot(cpu_pc, boot_start);
  assign spm_tgt_boot = in_boot(spm_addr, boot_start);
  assign spm_tgt_rww = in_rww(spm_addr);
  assign spm_wr_block = spm_tgt_boot ? boot_wr_block : app_wr_block;

  // blocked while the flag stands and for the whole of any page operation
  assign rww_blocked = s_reg.rww_busy | (s_reg.st == FSP_BUSY);

  // no_read_while_write_section code stays readable while an rww page is programmed
  assign fetch_blocked = rww_blocked & in_rww(fetch_addr);

  always_comb
  begin
    lpm_denied = 1'b0;
    if (lpm_req)
    begin
      if (rww_blocked && in_rww(lpm_addr))
      begin
        lpm_denied = 1'b1;
      end
      else if (pc_boot && !in_boot(lpm_addr, boot_start) && app_rd_block)
      begin
        lpm_denied = 1'b1;
      end
      else if (!pc_boot && in_boot(lpm_addr, boot_start) && boot_rd_block)
      begin
        lpm_denied = 1'b1;
      end
    end
  end

  // interrupts masked when the vectors sit in the other section and the running section is read-locked
  assign irq_masked = (!pc_boot && cpu_vectors_in_boot && app_rd_block)
                    | (pc_boot && !cpu_vectors_in_boot && boot_rd_block);

  // fuse is sampled continuously, so the vector is right on any reset
  assign reset_vector = boot_reset_select_fuse ? APP_RESET_ADDR : boot_start;

  // ----------------------------------------------------------------
  // control write decode
  // ----------------------------------------------------------------
  logic ctrl_wr;
  logic ctrl_legal;
  logic [3:0] ctrl_ops;

  assign ctrl_wr = reg_wr && (reg_addr == CTRL_ADDR);
  assign ctrl_ops = {reg_wdata[CTRL_RWW_REEN], reg_wdata[CTRL_LOCK_SET],
                     reg_wdata[CTRL_WRITE], reg_wdata[CTRL_ERASE]};
  // spm enable with at most one operation bit; anything else does nothing
  assign ctrl_legal = reg_wdata[CTRL_SPM_EN] && ($countones(ctrl_ops) <= 1);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.erase_pulse = 1'b0;
    s_next.write_pulse = 1'b0;
    s_next.lock_wr = 1'b0;

    unique case (s_reg.st)
      FSP_IDLE:
      begin
        if (ctrl_wr && ctrl_legal)
        begin
          s_next.st = FSP_ARMED;
          s_next.arm_cnt = SPM_ARM_CYC;
          s_next.cmd_erase = reg_wdata[CTRL_ERASE];
          s_next.cmd_write = reg_wdata[CTRL_WRITE];
          s_next.cmd_lock_set = reg_wdata[CTRL_LOCK_SET];
          s_next.cmd_rww_reen = reg_wdata[CTRL_RWW_REEN];
        end
      end

      FSP_ARMED:
      begin
        if (spm_exec)
        begin
          s_next.st = FSP_IDLE;
          s_next.cmd_erase = 1'b0;
          s_next.cmd_write = 1'b0;
          s_next.cmd_lock_set = 1'b0;
          s_next.cmd_rww_reen = 1'b0;
          // spm from the application section is a no-operation
          if (pc_boot)
          begin
            if (s_reg.cmd_erase || s_reg.cmd_write)
            begin
              // a locked target starts nothing at all
              if (!spm_wr_block)
              begin
                s_next.st = FSP_BUSY;
                s_next.page = spm_addr;
                s_next.erase_pulse = s_reg.cmd_erase;
                s_next.write_pulse = s_reg.cmd_write;
                s_next.halt = !spm_tgt_rww;
                if (spm_tgt_rww)
                begin
                  s_next.rww_busy = 1'b1;
                end
              end
            end
            else if (s_reg.cmd_lock_set)
            begin
              // and-ing with the current value can only program bits,
              // so erasing back to one is left to chip erase
              s_next.lock_wr = 1'b1;
              s_next.lock_val[LOCK_APP_LO - 1] = app_lock_bit_lo & spm_r0[LOCK_APP_LO];
              s_next.lock_val[LOCK_APP_HI - 1] = app_lock_bit_hi & spm_r0[LOCK_APP_HI];
              s_next.lock_val[LOCK_BOOT_LO - 1] = boot_lock_bit_lo & spm_r0[LOCK_BOOT_LO];
              s_next.lock_val[LOCK_BOOT_HI - 1] = boot_lock_bit_hi & spm_r0[LOCK_BOOT_HI];
            end
            else
            begin
              // re-enable, or a page buffer load, frees the rww section
              s_next.rww_busy = 1'b0;
            end
          end
        end
        else if (s_reg.arm_cnt == ARM_ONE)
        begin
          s_next.st = FSP_IDLE;
          s_next.arm_cnt = '0;
          s_next.cmd_erase = 1'b0;
          s_next.cmd_write = 1'b0;
          s_next.cmd_lock_set = 1'b0;
          s_next.cmd_rww_reen = 1'b0;
        end
        else
        begin
          s_next.arm_cnt = s_reg.arm_cnt - ARM_ONE;
        end
      end

      FSP_BUSY:
      begin
        // control writes are ignored: re-enable cannot act mid-operation
        if (flash_done)
        begin
          s_next.st = FSP_IDLE;
          s_next.halt = 1'b0;
        end
      end
    endcase

    // read data stands only in the cycle after the read strobe
    s_next.rdata = RDATA_RST;
    if (reg_rd)
    begin
      unique case (reg_addr)
        CTRL_ADDR:
        begin
          s_next.rdata[CTRL_SPM_EN] = (s_reg.st != FSP_IDLE);
          s_next.rdata[CTRL_ERASE] = s_reg.cmd_erase;
          s_next.rdata[CTRL_WRITE] = s_reg.cmd_write;
          s_next.rdata[CTRL_LOCK_SET] = s_reg.cmd_lock_set;
          s_next.rdata[CTRL_RWW_REEN] = s_reg.cmd_rww_reen;
          s_next.rdata[CTRL_RWW_BUSY] = s_reg.rww_busy;
        end
        STATUS_ADDR:
        begin
          s_next.rdata[STAT_RST_SEL] = boot_reset_select_fuse;
          s_next.rdata[STAT_SIZE_LO] = boot_size_fuses[0];
          s_next.rdata[STAT_SIZE_HI] = boot_size_fuses[1];
          s_next.rdata[STAT_OP_BUSY] = (s_reg.st == FSP_BUSY);
          s_next.rdata[STAT_HALT] = s_reg.halt;
        end
        LOCK_ADDR:
        begin
          s_next.rdata[LOCK_APP_LO] = app_lock_bit_lo;
          s_next.rdata[LOCK_APP_HI] = app_lock_bit_hi;
          s_next.rdata[LOCK_BOOT_LO] = boot_lock_bit_lo;
          s_next.rdata[LOCK_BOOT_HI] = boot_lock_bit_hi;
        end
        default:
        begin
          s_next.rdata = RDATA_RST;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= REGS_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s_reg.rdata;
  assign cpu_halt = s_reg.halt;
  assign flash_erase_start = s_reg.erase_pulse;
  assign flash_write_start = s_reg.write_pulse;
  assign flash_page_addr = s_reg.page;
  assign lock_wr = s_reg.lock_wr;
  assign lock_wr_data = s_reg.lock_val;

endmodule

/* File: tb/fsp_flash_model.sv */
module fsp_flash_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // flash array
  input wire logic flash_erase_start,
  input wire logic flash_write_start,
  input wire logic slow,
  output logic flash_done,
  // lock storage, {boot_hi, boot_lo, app_hi, app_lo}
  input wire logic lock_wr,
  input wire logic [3:0] lock_wr_data,
  input wire logic chip_erase,
  output logic [3:0] locks
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 0;
      flash_done <= 1'b0;
      locks <= 4'hF;
    end
    else
    begin
      flash_done <= (cnt == 1);
      // slow mode stretches the op so halt hold is watched over many cycles
      if (flash_erase_start || flash_write_start)
        cnt <= slow ? 20 : 3;
      else if (cnt != 0)
        cnt <= cnt - 1;
      if (chip_erase)
        locks <= 4'hF;
      else if (lock_wr)
        locks <= locks & lock_wr_data;
    end
  end
endmodule

/* File: tb/fsp_protect_checker.sv */
module fsp_protect_checker
  import fsp_pkg::*;
#(
  parameter logic [FLASH_AW-1:0] NO_READ_WHILE_WRITE_SECTION_START = 15'h4800
)(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic reg_rd,
  input wire logic [fsp_pkg::REG_DW-1:0] reg_rdata,
  // cpu side
  input wire logic [fsp_pkg::FLASH_AW-1:0] cpu_pc,
  input wire logic spm_exec,
  input wire logic [fsp_pkg::FLASH_AW-1:0] fetch_addr,
  input wire logic lpm_req,
  input wire logic [fsp_pkg::FLASH_AW-1:0] lpm_addr,
  input wire logic cpu_halt,
  input wire logic fetch_blocked,
  input wire logic lpm_denied,
  input wire logic [fsp_pkg::FLASH_AW-1:0] reset_vector,
  // fuses and locks
  input wire logic [1:0] boot_size_fuses,
  input wire logic boot_reset_select_fuse,
  input wire logic app_lock_bit_hi,
  input wire logic app_lock_bit_lo,
  input wire logic boot_lock_bit_hi,
  input wire logic boot_lock_bit_lo,
  input wire logic lock_wr,
  // flash array
  input wire logic flash_done,
  input wire logic flash_erase_start,
  input wire logic flash_write_start,
  input wire logic [fsp_pkg::FLASH_AW-1:0] flash_page_addr
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic start;
  logic rww_pg;
  assign start = flash_erase_start || flash_write_start;
  assign rww_pg = flash_page_addr < NO_READ_WHILE_WRITE_SECTION_START;
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_app_spm; spm_exec && cpu_pc < NO_READ_WHILE_WRITE_SECTION_START |=> !start && !lock_wr; endproperty
  a_app_spm: assert property (p_app_spm) else $error("spm from app acted");
  property p_halt_no_read_while_write_section; start && !rww_pg |-> cpu_halt; endproperty
  a_halt_no_read_while_write_section: assert property (p_halt_no_read_while_write_section) else $error("no_read_while_write_section op not halted");
  property p_run_rww; start && rww_pg |-> !cpu_halt; endproperty
  a_run_rww: assert property (p_run_rww) else $error("rww op halted cpu");
  property p_halt_hold; cpu_halt && !flash_done |=> cpu_halt; endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt dropped early");
  property p_halt_cause; $rose(cpu_halt) |-> start && !rww_pg; endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without no_read_while_write_section op");
  property p_fetch_rww; start && rww_pg && fetch_addr < NO_READ_WHILE_WRITE_SECTION_START |-> fetch_blocked; endproperty
  a_fetch_rww: assert property (p_fetch_rww) else $error("rww fetch open");
  property p_fetch_no_read_while_write_section; fetch_addr >= NO_READ_WHILE_WRITE_SECTION_START |-> !fetch_blocked; endproperty
  a_fetch_no_read_while_write_section: assert property (p_fetch_no_read_while_write_section) else $error("no_read_while_write_section fetch blocked");
  property p_app_wlock; start && !app_lock_bit_lo |-> !rww_pg; endproperty
  a_app_wlock: assert property (p_app_wlock) else $error("locked app written");
  property p_boot_wlock; start && !boot_lock_bit_lo |-> flash_page_addr < 15'h4F00; endproperty
  a_boot_wlock: assert property (p_boot_wlock) else $error("locked boot written");
  property p_app_rlock;
    lpm_req && !app_lock_bit_hi && boot_size_fuses == 2'h0 && cpu_pc >= NO_READ_WHILE_WRITE_SECTION_START
      && lpm_addr < NO_READ_WHILE_WRITE_SECTION_START |-> lpm_denied;
  endproperty
  a_app_rlock: assert property (p_app_rlock) else $error("app read not denied");
  property p_boot_rlock;
    lpm_req && !boot_lock_bit_hi && cpu_pc < NO_READ_WHILE_WRITE_SECTION_START && lpm_addr >= 15'h4F00
      && lpm_addr < 15'h5000 |-> lpm_denied;
  endproperty
  a_boot_rlock: assert property (p_boot_rlock) else $error("boot read not denied");
  property p_vec_app; boot_reset_select_fuse |-> reset_vector == 15'h0000; endproperty
  a_vec_app: assert property (p_vec_app) else $error("app vector wrong");
  property p_vec_boot; !boot_reset_select_fuse |-> reset_vector >= NO_READ_WHILE_WRITE_SECTION_START; endproperty
  a_vec_boot: assert property (p_vec_boot) else $error("boot vector outside no_read_while_write_section");
endmodule

bind fsp_protect fsp_protect_checker #(.NO_READ_WHILE_WRITE_SECTION_START(NO_READ_WHILE_WRITE_SECTION_START)) chk_i (.clock, .rst, .reg_rd,
  .reg_rdata, .cpu_pc, .spm_exec, .fetch_addr, .lpm_req, .lpm_addr, .cpu_halt, .fetch_blocked,
  .lpm_denied, .reset_vector, .boot_size_fuses, .boot_reset_select_fuse, .app_lock_bit_hi,
  .app_lock_bit_lo, .boot_lock_bit_hi, .boot_lock_bit_lo, .lock_wr, .flash_done,
  .flash_erase_start, .flash_write_start, .flash_page_addr);

/* File: tb/flash_self_program_protection_tb_top.sv */
module flash_self_program_protection_tb_top;
  import fsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [1:0] sz; logic rf; logic [FLASH_AW-1:0] vec;} fsp_row_t;
  fsp_row_t rows [5] = '{'{2'h3, 1'b1, 15'h0000}, '{2'h3, 1'b0, 15'h4F00},
    '{2'h2, 1'b0, 15'h4E00}, '{2'h1, 1'b0, 15'h4C00}, '{2'h0, 1'b0, 15'h4800}};
  logic clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, spm_exec = 1'b0;
  logic lpm_req = 1'b0, cpu_vectors_in_boot = 1'b0, slow = 1'b0, chip_erase = 1'b0;
  logic boot_reset_select_fuse = 1'b1;
  logic [1:0] boot_size_fuses = 2'h3;
  logic [3:0] reg_addr = 4'h0, lock_wr_data, locks;
  logic [7:0] reg_wdata = 8'h00, spm_r0 = 8'h00, reg_rdata, d;
  logic [FLASH_AW-1:0] cpu_pc = 15'h0000, spm_addr = 15'h0000, lpm_addr = 15'h0000;
  logic [FLASH_AW-1:0] fetch_addr = 15'h0040, reset_vector, flash_page_addr;
  logic cpu_halt, fetch_blocked, lpm_denied, irq_masked, lock_wr, flash_done;
  logic flash_erase_start, flash_write_start;
  int fails = 0, n_checks = 0;
  always #50 clock = ~clock;
  fsp_protect dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_pc,
    .cpu_vectors_in_boot, .spm_exec, .spm_addr, .spm_r0, .fetch_addr, .lpm_req, .lpm_addr,
    .cpu_halt, .fetch_blocked, .lpm_denied, .irq_masked, .reset_vector, .boot_size_fuses,
    .boot_reset_select_fuse, .app_lock_bit_hi(locks[1]), .app_lock_bit_lo(locks[0]),
    .boot_lock_bit_hi(locks[3]), .boot_lock_bit_lo(locks[2]), .lock_wr, .lock_wr_data,
    .flash_done, .flash_erase_start, .flash_write_start, .flash_page_addr);
  fsp_flash_model flash (.clock, .rst, .flash_erase_start, .flash_write_start, .slow,
    .flash_done, .lock_wr, .lock_wr_data, .chip_erase, .locks);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // arm through the control register, then spm at the next edge; returns with the answer visible
  task automatic op(input logic [7:0] c, input logic [FLASH_AW-1:0] pc, a, input logic [7:0] r);
    wr(CTRL_ADDR, c);
    @(posedge clock);
    cpu_pc <= pc;
    spm_addr <= a;
    spm_r0 <= r;
    spm_exec <= 1'b1;
    @(posedge clock);
    spm_exec <= 1'b0;
    #1;
  endtask
  task automatic wait_done;
    int i;
    for (i = 0; i < 100 && flash_done !== 1'b1; i++)
      @(posedge clock) #1;
    if (i == 100)
    begin
      fails++;
      wrap_up();
    end
    @(posedge clock) #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[k])
    begin
      @(posedge clock);
      boot_size_fuses <= rows[k].sz;
      boot_reset_select_fuse <= rows[k].rf;
      rd(STATUS_ADDR);
      chk(reset_vector === rows[k].vec, "reset vector");
      chk(d === {2'b00, rows[k].sz, rows[k].rf, 3'b000}, "status fuses");
    end
    rd(4'hF);
    chk(d === 8'h00, "unmapped read");
    wr(CTRL_ADDR, 8'h07);
    rd(CTRL_ADDR);
    chk(d === 8'h00, "two op bits ignored");
    op(8'h03, 15'h0100, 15'h0040, 8'h00);
    chk(flash_erase_start === 1'b0 && cpu_halt === 1'b0, "spm from app");
    rd(CTRL_ADDR);
    chk(d === 8'h00, "app spm disarms");
    op(8'h03, 15'h4F10, 15'h0040, 8'h00);
    chk(flash_erase_start === 1'b1 && cpu_halt === 1'b0, "rww erase");
    chk(fetch_blocked === 1'b1 && flash_page_addr === 15'h0040, "rww fetch");
    fetch_addr <= 15'h4900;
    rd(CTRL_ADDR);
    chk(d[6] === 1'b1 && fetch_blocked === 1'b0, "busy flag, no_read_while_write_section fetch");
    wait_done();
    fetch_addr <= 15'h0040;
    rd(CTRL_ADDR);
    chk(d[6] === 1'b1 && fetch_blocked === 1'b1, "busy after op");
    op(8'h11, 15'h4F10, 15'h0000, 8'h00);
    chk(fetch_blocked === 1'b0, "rww reopened");
    rd(CTRL_ADDR);
    chk(d[6] === 1'b0, "busy cleared");
    slow <= 1'b1;
    op(8'h05, 15'h4F10, 15'h4F80, 8'h00);
    chk(flash_write_start === 1'b1 && cpu_halt === 1'b1, "boot page write");
    rd(STATUS_ADDR);
    chk(d === 8'hC0, "status busy and halt");
    wait_done();
    chk(cpu_halt === 1'b0, "halt released");
    slow <= 1'b0;
    op(8'h09, 15'h4F10, 15'h0000, 8'hFD);
    chk(lock_wr === 1'b1 && lock_wr_data === 4'hE, "app lock 10");
    op(8'h03, 15'h4F10, 15'h0040, 8'h00);
    chk(flash_erase_start === 1'b0 && cpu_halt === 1'b0, "app write locked");
    lpm_addr <= 15'h0040;
    lpm_req <= 1'b1;
    #1 chk(lpm_denied === 1'b0, "app read open");
    op(8'h03, 15'h4F10, 15'h4F80, 8'h00);
    chk(flash_erase_start === 1'b1, "boot page open");
    wait_done();
    op(8'h09, 15'h4F10, 15'h0000, 8'hFB);
    chk(lock_wr_data === 4'hC, "app lock 00");
    @(posedge clock) #1;
    chk(lpm_denied === 1'b1, "boot reads app");
    cpu_vectors_in_boot <= 1'b1;
    cpu_pc <= 15'h0100;
    #1 chk(irq_masked === 1'b1, "app irq masked");
    cpu_vectors_in_boot <= 1'b0;
    op(8'h09, 15'h4F10, 15'h0000, 8'hEF);
    chk(lock_wr_data === 4'h4, "locks only set");
    @(posedge clock) #1;
    cpu_pc <= 15'h0100;
    lpm_addr <= 15'h4F80;
    #1 chk(lpm_denied === 1'b1, "app reads boot");
    op(8'h05, 15'h4F10, 15'h4F80, 8'h00);
    chk(flash_write_start === 1'b1, "boot write open");
    wait_done();
    op(8'h09, 15'h4F10, 15'h0000, 8'hF7);
    chk(lock_wr_data === 4'h0, "boot lock 00");
    op(8'h05, 15'h4F10, 15'h4F80, 8'h00);
    chk(flash_write_start === 1'b0 && cpu_halt === 1'b0, "boot write locked");
    lpm_req <= 1'b0;
    chip_erase <= 1'b1;
    @(posedge clock) chip_erase <= 1'b0;
    #1 chk(locks === 4'hF, "chip erase clears");
    op(8'h03, 15'h4F10, 15'h0040, 8'h00);
    rst <= 1'b1;
    @(posedge clock) rst <= 1'b0;
    #1 chk(cpu_halt === 1'b0 && fetch_blocked === 1'b0, "mid-run reset");
    rd(CTRL_ADDR);
    chk(d === 8'h00, "control after reset");
    wrap_up();
  end
endmodule
